/* logic/xop_core.sv */
`timescale 1ns/1ps
`default_nettype none
module xop_core (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // instruction issue
  input wire logic OP_VALID_I,
  input wire xop_pkg::op_type OP_I,
  input wire logic [xop_pkg::FILE_AW-1:0] FILE_ADDR_I,
  input wire logic DEST_I,
  input wire logic [xop_pkg::DATA_W-1:0] LITERAL_I,
  input wire logic [xop_pkg::DATA_W-1:0] FILE_RDATA_I,
  input wire logic PTR_WE_I,
  input wire logic [xop_pkg::DATA_W-1:0] PTR_WDATA_I,
  input wire logic [xop_pkg::ROM_DW-1:0] ROM_DATA_I,
  // file write-back
  output logic FILE_WE_O,
  output logic [xop_pkg::FILE_AW-1:0] FILE_WADDR_O,
  output logic [xop_pkg::DATA_W-1:0] FILE_WDATA_O,
  // rom port and state
  output logic [xop_pkg::ROM_AW-1:0] ROM_ADDR_O,
  output logic BUSY_O,
  output logic [xop_pkg::DATA_W-1:0] ACC_O,
  output logic [xop_pkg::DATA_W-1:0] TIMER0_MODE_O,
  output logic [xop_pkg::DATA_W-1:0] LOOKUP_DATA_HIGH_O,
  output logic ZERO_FLAG_O,
  output logic ZERO_WE_O
);
  import xop_pkg::*;
  // architectural state
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] mode_q;
  logic [DATA_W-1:0] ptr_q;
  logic [DATA_W-1:0] high_q;
  logic zero_q;
  // datapath results
  logic [DATA_W-1:0] swap_res;
  logic [DATA_W-1:0] xor_src;
  logic [DATA_W-1:0] xor_res;
  // registered strobes and write-back
  logic zwe_q;
  logic busy_q;
  logic fwe_q;
  logic [FILE_AW-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [ROM_AW-1:0] rom_addr_q;
  // decode
  logic take;
  logic is_swap;
  logic is_xf;
  logic is_xl;
  logic wr_file;

  nibble_exchange_unit u_swap (
    .src_i(FILE_RDATA_I),
    .res_o(swap_res)
  );

  assign take = OP_VALID_I && !busy_q;
  assign is_swap = take && OP_I == OP_NIBBLE_EXCHANGE;
  assign is_xf = take && OP_I == OP_XOR_WITH_FILE;
  assign is_xl = take && OP_I == OP_XOR_WITH_LITERAL;
  assign xor_src = is_xl ? LITERAL_I : FILE_RDATA_I;
  assign xor_res = acc_q ^ xor_src;
  assign wr_file = (is_swap || is_xf) && DEST_I;

  // accumulator; lookup result lands on the second cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      acc_q <= ACC_RESET;
    end else if (busy_q) begin
      acc_q <= ROM_DATA_I[DATA_W-1:0];
    end else if (is_swap && !DEST_I) begin
      acc_q <= swap_res;
    end else if (is_xl || (is_xf && !DEST_I)) begin
      acc_q <= xor_res;
    end else if (take && OP_I == OP_TIMER0_MODE_READBACK) begin
      acc_q <= mode_q;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      mode_q <= MODE_RESET;
    end else if (take && OP_I == OP_TIMER0_MODE_LOAD) begin
      mode_q <= acc_q;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ptr_q <= PTR_RESET;
    end else if (PTR_WE_I) begin
      ptr_q <= PTR_WDATA_I;
    end
  end

  // two-cycle lookup: issue latches address, second cycle returns data
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      busy_q <= 1'b0;
      rom_addr_q <= '0;
    end else begin
      busy_q <= take && OP_I == OP_ROM_LOOKUP;
      if (take && OP_I == OP_ROM_LOOKUP) begin
        rom_addr_q <= {ptr_q[PTR_LSB_W-1:0], acc_q};
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      high_q <= HIGH_RESET;
    end else if (busy_q) begin
      high_q <= {2'h0, ROM_DATA_I[ROM_DW-1:DATA_W]};
    end
  end

  // only the xor ops touch the zero flag
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      zero_q <= 1'b0;
      zwe_q <= 1'b0;
    end else begin
      zwe_q <= is_xf || is_xl;
      if (is_xf || is_xl) begin
        zero_q <= (xor_res == ZERO_BYTE);
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      fwe_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= ZERO_BYTE;
    end else begin
      fwe_q <= wr_file;
      if (wr_file) begin
        waddr_q <= FILE_ADDR_I;
        wdata_q <= is_swap ? swap_res : xor_res;
      end
    end
  end

  assign FILE_WE_O = fwe_q;
  assign FILE_WADDR_O = waddr_q;
  assign FILE_WDATA_O = wdata_q;
  assign ROM_ADDR_O = rom_addr_q;
  assign BUSY_O = busy_q;
  assign ACC_O = acc_q;
  assign TIMER0_MODE_O = mode_q;
  assign LOOKUP_DATA_HIGH_O = high_q;
  assign ZERO_FLAG_O = zero_q;
  assign ZERO_WE_O = zwe_q;

  AST_MODE_LOAD: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    take && OP_I == OP_TIMER0_MODE_LOAD |=> mode_q == $past(acc_q) && !zwe_q)
    else $error("mode load wrong");
  AST_MODE_READ: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    take && OP_I == OP_TIMER0_MODE_READBACK |=> acc_q == $past(mode_q) && !zwe_q)
    else $error("mode read wrong");
  AST_LOOKUP_ADDR: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    take && OP_I == OP_ROM_LOOKUP |=> busy_q && ROM_ADDR_O == {$past(ptr_q[2:0]), $past(acc_q)})
    else $error("lookup address wrong");
  AST_LOOKUP_DATA: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    busy_q |=> acc_q == $past(ROM_DATA_I[7:0]) && high_q == {2'h0, $past(ROM_DATA_I[13:8])} && !busy_q)
    else $error("lookup data wrong");
  AST_SWAP_FILE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    is_swap && DEST_I |=> FILE_WE_O && FILE_WDATA_O == {$past(FILE_RDATA_I[3:0]), $past(FILE_RDATA_I[7:4])})
    else $error("swap write-back wrong");
  AST_SWAP_ACC: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    is_swap && !DEST_I |=> !FILE_WE_O && acc_q == {$past(FILE_RDATA_I[3:0]), $past(FILE_RDATA_I[7:4])})
    else $error("swap to accumulator wrong");
  AST_XOR_FILE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    is_xf && DEST_I |=> FILE_WDATA_O == ($past(acc_q) ^ $past(FILE_RDATA_I)) && acc_q == $past(acc_q))
    else $error("file xor wrong");
  AST_XOR_LIT: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    is_xl |=> acc_q == ($past(acc_q) ^ $past(LITERAL_I)) && zwe_q)
    else $error("literal xor wrong");
  AST_ZERO: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    zwe_q |-> zero_q == (($past(acc_q) ^ $past(xor_src)) == 8'h00))
    else $error("zero flag wrong");
  AST_XOR_ACC: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    is_xf && !DEST_I |=> !FILE_WE_O && zwe_q && acc_q == ($past(acc_q) ^ $past(FILE_RDATA_I)))
    else $error("file xor to accumulator wrong");
  AST_SWAP_FLAGS: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    is_swap |=> !zwe_q && zero_q == $past(zero_q))
    else $error("swap touched the zero flag");
  AST_MODE_FLAGS: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    take && OP_I == OP_TIMER0_MODE_LOAD |=> zero_q == $past(zero_q) && acc_q == $past(acc_q))
    else $error("mode load disturbed state");
  AST_READ_FLAGS: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    take && OP_I == OP_TIMER0_MODE_READBACK |=> zero_q == $past(zero_q) && mode_q == $past(mode_q))
    else $error("mode read disturbed state");
  AST_LOOKUP_FLAGS: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    busy_q |=> !zwe_q && zero_q == $past(zero_q))
    else $error("lookup touched the zero flag");
  AST_BUSY_DROP: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    busy_q |=> !FILE_WE_O && mode_q == $past(mode_q))
    else $error("op accepted while lookup busy");
  AST_LOOKUP_TWO: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    take && OP_I == OP_ROM_LOOKUP |=> busy_q ##1 !busy_q)
    else $error("lookup not two cycles");
  AST_XOR_ZWE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    is_xf |=> zwe_q)
    else $error("file xor did not update zero flag");
  AST_FILE_ADDR: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_file |=> FILE_WE_O && FILE_WADDR_O == $past(FILE_ADDR_I))
    else $error("write-back address wrong");
  AST_HIGH_TOP: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    high_q[DATA_W-1:HIGH_W] == '0)
    else $error("data high top bits set");

  // the main scenarios that the bench should reach
  COV_LOOKUP: cover property (@(posedge CORE_CLK_I) take && OP_I == OP_ROM_LOOKUP ##2 !busy_q);
  COV_XOR_ACC: cover property (@(posedge CORE_CLK_I) is_xf && !DEST_I);
  COV_SWAP_FILE: cover property (@(posedge CORE_CLK_I) is_swap && DEST_I);
  COV_XOR_ZERO: cover property (@(posedge CORE_CLK_I) zwe_q && zero_q);
  COV_MODE: cover property (@(posedge CORE_CLK_I) take && OP_I == OP_TIMER0_MODE_LOAD);
endmodule
`default_nettype wire

/* logic/xop_pkg.sv */
package xop_pkg;
  localparam int DATA_W = 8;
  localparam int FILE_AW = 7;
  localparam int ROM_AW = 11;
  localparam int ROM_DW = 14;
  localparam int PTR_LSB_W = 3;
  localparam int HIGH_W = 6;
  localparam int NIB_W = 4;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_NIBBLE_EXCHANGE,
    OP_XOR_WITH_FILE,
    OP_XOR_WITH_LITERAL,
    OP_TIMER0_MODE_LOAD,
    OP_TIMER0_MODE_READBACK,
    OP_ROM_LOOKUP
  } op_type;
endpackage

/* logic/nibble_exchange_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module nibble_exchange_unit (
  input wire logic [7:0] src_i,
  output logic [7:0] res_o
);
  import xop_pkg::*;
  assign res_o = {src_i[NIB_W-1:0], src_i[DATA_W-1:NIB_W]};
endmodule
`default_nettype wire

/* verif/test_cpu_swap_xor_table_ops.sv */
`timescale 1ns/1ps
`default_nettype none
module test_cpu_swap_xor_table_ops;
  import xop_pkg::*;
  logic clk = 0, rst = 1, vld = 0, dst = 0, pwe = 0, zf = 0, we, zwe;
  op_type opc = OP_NONE;
  logic [6:0] adr = 0;
  logic [7:0] lit = 0, pwd = 0, acc = 0, mode = 0, ptr = 0, high = 0, r, res;
  logic [13:0] w;
  logic [15:0] seed = 16'd31337;
  logic [7:0] rf [128];
  logic fwe, busy, zf_o, zwe_o;
  logic [6:0] fwa;
  logic [7:0] fwd, acc_o, mode_o, high_o;
  logic [10:0] rom_a;
  int err_total = 0, checks_done = 0;
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // every word differs from its neighbours so a wrong pointer shows
  function automatic logic [13:0] rom_f(input logic [10:0] a);
    return {a[2:0], a} ^ 14'h35aa;
  endfunction
  wire logic [13:0] rom_d = rom_f(rom_a);
  always #2 clk = ~clk;
  always @(posedge clk) if (fwe) rf[fwa] <= fwd;
  xop_core i_dut(.CORE_CLK_I(clk), .RST_I(rst), .OP_VALID_I(vld), .OP_I(opc), .FILE_ADDR_I(adr), .DEST_I(dst),
    .LITERAL_I(lit), .FILE_RDATA_I(rf[adr]), .PTR_WE_I(pwe), .PTR_WDATA_I(pwd), .ROM_DATA_I(rom_d),
    .FILE_WE_O(fwe), .FILE_WADDR_O(fwa), .FILE_WDATA_O(fwd), .ROM_ADDR_O(rom_a), .BUSY_O(busy),
    .ACC_O(acc_o), .TIMER0_MODE_O(mode_o), .LOOKUP_DATA_HIGH_O(high_o), .ZERO_FLAG_O(zf_o), .ZERO_WE_O(zwe_o));
  task results;
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic pl(input logic [7:0] v);
    pwe = 1;
    pwd = v;
    ptr = v;
    @(negedge clk);
    pwe = 0;
  endtask
  task automatic op(input op_type o, input logic [6:0] a, input logic d, input logic [7:0] l);
    vld = 1; opc = o; adr = a; dst = d; lit = l; r = rf[a]; zwe = 0; res = acc;
    case (o)
      OP_NIBBLE_EXCHANGE: res = {r[3:0], r[7:4]};
      OP_XOR_WITH_FILE: begin res = acc ^ r; zwe = 1; end
      OP_XOR_WITH_LITERAL: begin res = acc ^ l; zwe = 1; end
      OP_TIMER0_MODE_LOAD: mode = acc;
      OP_TIMER0_MODE_READBACK: res = mode;
      default: ;
    endcase
    we = d && (o == OP_NIBBLE_EXCHANGE || o == OP_XOR_WITH_FILE);
    if (zwe) zf = (res == 8'h00);
    if (!we) acc = res;
    @(negedge clk);
    vld = 0;
    if (o == OP_ROM_LOOKUP) begin
      chk(busy, 1);
      chk(rom_a, {ptr[2:0], acc});
      // offered while busy, so it must be dropped
      vld = 1; opc = OP_XOR_WITH_LITERAL; lit = 8'hff;
      w = rom_f({ptr[2:0], acc}); acc = w[7:0]; high = {2'b00, w[13:8]};
      @(negedge clk);
      vld = 0;
    end
    chk(fwe, we);
    if (we) chk({fwa, fwd}, {a, res});
    chk(zwe_o, zwe);
    chk({acc_o, zf_o}, {acc, zf});
    chk({mode_o, high_o}, {mode, high});
  endtask
  initial begin
    for (int i = 0; i < 128; i++) rf[i] = 8'(rnd());
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk({busy, fwe, zf_o, zwe_o}, 0);
    chk(acc_o | mode_o | high_o, 0);
    rf[5] = 8'ha5;
    op(OP_NIBBLE_EXCHANGE, 5, 1, 0);
    // the register file takes the write-back one edge after it is offered
    op(OP_XOR_WITH_LITERAL, 0, 0, 8'hf0);
    chk(rf[5], 8'h5a);
    op(OP_XOR_WITH_LITERAL, 0, 0, 8'hf0);
    op(OP_XOR_WITH_LITERAL, 0, 0, 8'h34);
    pl(8'h02);
    op(OP_ROM_LOOKUP, 0, 0, 0);
    op(OP_XOR_WITH_FILE, 127, 1, 0);
    op(OP_TIMER0_MODE_LOAD, 0, 0, 0);
    op(OP_TIMER0_MODE_READBACK, 0, 0, 0);
    for (int n = 0; n < 400; n++) begin
      if (rnd() % 4 == 0) pl(8'(rnd()));
      op(op_type'(3'(rnd() % 6 + 1)), 7'(rnd()), 1'(rnd()), 8'(rnd()));
    end
    results();
  end
  // about 600 cycles are expected; this allows over ten times that
  initial begin
    #40000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
